// ### src/cmd_queue_tracker.sv
// count of commands accepted and not yet completed
// assumes: accept and complete are one-cycle pulses on mclk
`timescale 1ns/1ps
module cmd_queue_tracker
(
  input wire logic mclk,
  input wire logic rst,
  queue_track_if.owner q
);
  logic [5:0] count_nxt;
  logic ovf_nxt;
  wire take = q.accept && (q.count < q.limit);
  wire drop = q.complete && (q.count != 6'h00);
  assign ovf_nxt = q.accept && !take;
  assign count_nxt = take && !drop ? 6'(q.count + 6'h01) :
                     drop && !take ? 6'(q.count - 6'h01) : q.count;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      q.count <= 6'h00;
      q.full <= 1'b0;
      q.overflow <= 1'b0;
    end
    else
    begin
      q.count <= count_nxt;
      q.full <= (count_nxt >= q.limit);
      q.overflow <= ovf_nxt;
    end
endmodule

// ### src/dma_pace_monitor.sv
// watches host dma word spacing against the recommended cycle
// assumes: word_strobe is a one-cycle pulse per host word on mclk
`timescale 1ns/1ps
`include "ident_xfer_map.svh"
module dma_pace_monitor
  import ident_xfer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic word_strobe,
  input wire logic [15:0] rec_ns,
  output logic throttle
);
  localparam logic [16:0] PERIOD = 17'(`CLK_PERIOD_NS);
  pace_state_t state_r, state_nxt;
  logic [15:0] gap_r, gap_nxt;
  // least time, so round the cycle count up
  wire [15:0] rec_cyc = 16'((17'(rec_ns) + PERIOD - 17'h00001) / PERIOD);
  wire gap_top = (gap_r == 16'hFFFF);
  wire [15:0] gap_inc = gap_top ? gap_r : 16'(gap_r + 16'h0001);
  wire too_fast = word_strobe && (rec_ns != 16'h0000) && (gap_r < rec_cyc);
  always_comb
  begin
    state_nxt = state_r;
    gap_nxt = gap_inc;
    case (state_r)
      PACE_IDLE:
        if (word_strobe)
        begin
          state_nxt = PACE_RUN;
          gap_nxt = 16'h0001;
        end
      PACE_RUN:
        if (too_fast)
        begin
          state_nxt = PACE_HOLD;
          gap_nxt = 16'h0001;
        end
        else if (word_strobe)
          gap_nxt = 16'h0001;
      PACE_HOLD:
        if (gap_r >= rec_cyc)
          state_nxt = PACE_RUN;
      default:
        state_nxt = PACE_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      state_r <= PACE_IDLE;
      gap_r <= 16'h0000;
      throttle <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      gap_r <= gap_nxt;
      throttle <= (state_nxt == PACE_HOLD);
    end
endmodule

// ### src/ident_xfer_map.svh
// constants of the identify transfer-capability words
// assumes: included by bare name, holds definitions only
`ifndef IDENT_XFER_MAP_SVH
`define IDENT_XFER_MAP_SVH
`define CLK_PERIOD_NS 20
// word indexes within the identify data
`define W_MULT_SET 8'h3B
`define W_SECT_LO 8'h3C
`define W_SECT_HI 8'h3D
`define W_MWDMA 8'h3F
`define W_PIO_SUP 8'h40
`define W_DMA_MIN 8'h41
`define W_DMA_REC 8'h42
`define W_PIO_NOFC 8'h43
`define W_PIO_IORDY 8'h44
`define W_QUEUE 8'h4B
// field positions
`define MULT_VALID_BIT 8
`define MWDMA_SEL_LSB 8
`define PIO3_BIT 0
`define PIO4_BIT 1
// defined bits of each word; all others are reserved
`define MULT_USED_MASK 16'h01FF
`define MWDMA_USED_MASK 16'h0707
`define PIO_USED_MASK 16'h0003
`define QUEUE_USED_MASK 16'h001F
// capability straps of this device
`define MWDMA_PRESENT 1'b1
`define MWDMA_TOP_MODE 2'h2
`define PIO4_PRESENT 1'b1
`define CARD_CLASS 1'b0
`define UDMA_SUPPORT 7'h3F
`define MULT_MAX 8'h10
`define MULT_RESET 8'h10
`define QUEUED_PRESENT 1'b1
`define QUEUE_OVERLAP_ONLY 1'b0
`define QUEUE_DEPTH 6'h20
`define SECTORS_RESET 32'h0000_0000
// cycle times in ns
`define DMA_MIN_NS 16'h0078
`define DMA_REC_NS 16'h0078
`define PIO_NOFC_NS 16'h0078
`define PIO_IORDY_NS 16'h0078
`define MW0_CYCLE_NS 16'h01E0
`define MW1_CYCLE_NS 16'h0096
`define MW2_CYCLE_NS 16'h0078
`define PIO3_CYCLE_NS 16'h00B4
`define PIO4_CYCLE_NS 16'h0078
`define PIO_IORDY_MAX_NS 16'h00B4
// transfer mode codes, value bits 7..3
`define XM_PIO_DEF 5'h00
`define XM_PIO_FC 5'h01
`define XM_MWDMA 5'h04
`define XM_UDMA 5'h08
`endif

// ### src/ident_xfer_pkg.sv
// types shared by the identify transfer-capability block
// assumes: compiled before every module of the block
package ident_xfer_pkg;
  typedef logic [15:0] ident_word_t;
  typedef enum logic [2:0] {MC_PIO_DEF, MC_PIO_FC, MC_MWDMA, MC_UDMA, MC_BAD} mode_class_t;
  typedef enum logic [1:0] {PACE_IDLE, PACE_RUN, PACE_HOLD} pace_state_t;
endpackage

// ### src/ident_xfer_words.sv
// identify transfer-capability words: multiple setting, capacity,
// multiword dma, pio modes, cycle times and queue depth
// assumes: all inputs come from logic on mclk; requests are pulses
//
// Function
// - bit 8 flags valid multiple sector count
// - only one dma mode selected at once
// - multiword selected bits stay one-hot or zero
// - reserved bits always read zero
// - mode 2 support implies modes 1, 0
// - mode 1 support implies mode 0
// - bit 0 set exactly when mode 0
// - pio field: bit0 mode3, bit1 mode4
// - pio mode 3 bit set unless card class without mode 4
// - pio or cycle fields set validity flag
// - validity flag covers words 64 to 70
// - unsupported cycle field reads zero
// - dma minimum not below fastest mode
// - recommended not below dma minimum
// - fast host words may throttle dmarq
// - no-flow pio not below iordy cycle
// - iordy cycle fastest mode, max 180
// - queue depth reported as depth minus one
// - outstanding accepted commands form queue depth
// - zero depth when unqueued or overlap only
// - 32-bit sector count over two words
`timescale 1ns/1ps
`include "ident_xfer_map.svh"
module ident_xfer_words
  import ident_xfer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic [7:0] rd_index,
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic mult_set_req,
  input wire logic [7:0] mult_set_count,
  input wire logic mode_set_req,
  input wire logic [7:0] mode_set_value,
  output logic set_done,
  output logic set_reject,
  input wire logic cap_load,
  input wire logic [31:0] cap_sectors,
  input wire logic cmd_accept,
  input wire logic cmd_complete,
  output logic [5:0] queue_count,
  output logic queue_full,
  output logic queue_overflow,
  input wire logic dma_word_strobe,
  output logic dmarq_throttle,
  output logic words_64_70_valid,
  output logic [2:0] mwdma_sel,
  output logic [6:0] udma_sel
);

  ////////////////////////////////////////////////////////////////////
  // fixed capability words

  wire mw2_sup = `MWDMA_PRESENT && (`MWDMA_TOP_MODE >= 2'h2);
  wire mw1_sup = `MWDMA_PRESENT && (`MWDMA_TOP_MODE >= 2'h1);
  wire mw0_sup = `MWDMA_PRESENT;
  wire [2:0] mw_sup = {mw2_sup, mw1_sup, mw0_sup};

  wire pio3_sup = !`CARD_CLASS || `PIO4_PRESENT;
  wire pio4_sup = `PIO4_PRESENT;
  wire [15:0] pio_word = {14'h0000, pio4_sup, pio3_sup};

  // fastest supported multiword mode sets the floor for the minimum
  wire [15:0] mw_floor = mw2_sup ? `MW2_CYCLE_NS :
                         mw1_sup ? `MW1_CYCLE_NS : `MW0_CYCLE_NS;
  wire [15:0] dma_min_raw = (`DMA_MIN_NS < mw_floor) ? mw_floor : `DMA_MIN_NS;
  wire [15:0] dma_rec_raw = (`DMA_REC_NS < dma_min_raw) ? dma_min_raw : `DMA_REC_NS;
  wire [15:0] dma_min_word = mw_sup[0] ? dma_min_raw : 16'h0000;
  wire [15:0] dma_rec_word = mw_sup[0] ? dma_rec_raw : 16'h0000;

  wire [15:0] iordy_mode = pio4_sup ? `PIO4_CYCLE_NS : `PIO3_CYCLE_NS;
  wire [15:0] iordy_raw = (iordy_mode > `PIO_IORDY_MAX_NS) ? `PIO_IORDY_MAX_NS :
                          iordy_mode;
  wire [15:0] nofc_raw = (`PIO_NOFC_NS < iordy_raw) ? iordy_raw : `PIO_NOFC_NS;
  wire [15:0] iordy_word = pio3_sup ? iordy_raw : 16'h0000;
  wire [15:0] nofc_word = pio3_sup ? nofc_raw : 16'h0000;

  wire fields_present = pio3_sup || pio4_sup || mw_sup[0];

  wire queuing = `QUEUED_PRESENT && !`QUEUE_OVERLAP_ONLY;
  wire [4:0] depth_code = queuing ? 5'(`QUEUE_DEPTH - 6'h01) : 5'h00;
  wire [15:0] queue_word = {11'h000, depth_code};
  // overlap-only still takes one command at a time
  wire [5:0] queue_limit = !`QUEUED_PRESENT ? 6'h00 :
                           queuing ? `QUEUE_DEPTH : 6'h01;

  ////////////////////////////////////////////////////////////////////
  // decode of the set-features transfer mode value

  wire [4:0] xm_kind = mode_set_value[7:3];
  wire [2:0] xm_num = mode_set_value[2:0];
  // pio default only for its two plain codes
  wire is_pio_def = (xm_kind == `XM_PIO_DEF) && (xm_num <= 3'h1);
  wire is_pio_fc = (xm_kind == `XM_PIO_FC);
  wire is_mwdma = (xm_kind == `XM_MWDMA);
  wire is_udma = (xm_kind == `XM_UDMA);
  mode_class_t xm_class;
  assign xm_class = is_pio_def ? MC_PIO_DEF :
                    is_pio_fc ? MC_PIO_FC :
                    is_mwdma ? MC_MWDMA :
                    is_udma ? MC_UDMA : MC_BAD;

  // padded to eight bits so every mode number indexes a real bit
  wire [7:0] udma_cap = {1'b0, `UDMA_SUPPORT};
  wire pio_fc_ok = (xm_num <= 3'h3) || (xm_num == 3'h4 && pio4_sup);
  wire mw_ok = (xm_num <= 3'h2) && mw_sup[xm_num[1:0]];
  wire ud_ok = (xm_num <= 3'h6) && udma_cap[xm_num];

  wire mode_ok = (xm_class == MC_PIO_DEF) ||
                 (xm_class == MC_PIO_FC && pio_fc_ok) ||
                 (xm_class == MC_MWDMA && mw_ok) ||
                 (xm_class == MC_UDMA && ud_ok);

  // one-hot of the requested mode number
  wire [6:0] num_hot = 7'(8'h01 << xm_num);

  ////////////////////////////////////////////////////////////////////
  // current settings

  logic [2:0] mwdma_nxt;
  logic [6:0] udma_nxt;
  logic [7:0] mult_count_r, mult_count_nxt;
  logic mult_on_r, mult_on_nxt;
  logic [31:0] sectors_r;
  logic [15:0] sect_hi_snap_r;

  // count above the largest block size is refused
  wire mult_ok = (mult_set_count <= `MULT_MAX);
  wire mode_take = mode_set_req && mode_ok;
  wire mult_take = mult_set_req && mult_ok;
  // a refused request leaves every setting as it was
  wire mode_rej = mode_set_req && !mode_ok;
  wire mult_rej = mult_set_req && !mult_ok;
  wire any_reject = mode_rej || mult_rej;

  always_comb
  begin
    mwdma_nxt = mwdma_sel;
    udma_nxt = udma_sel;
    if (mode_take)
    begin
      case (xm_class)
        MC_MWDMA:
        begin
          mwdma_nxt = num_hot[2:0];
          udma_nxt = 7'h00;
        end
        MC_UDMA:
        begin
          mwdma_nxt = 3'h0;
          udma_nxt = num_hot;
        end
        default:
        begin
          mwdma_nxt = mwdma_sel;
          udma_nxt = udma_sel;
        end
      endcase
    end
  end

  // block size updated at once
  // a count of zero turns multiple transfers off
  assign mult_count_nxt = mult_take ? mult_set_count : mult_count_r;
  assign mult_on_nxt = mult_take ? (mult_set_count != 8'h00) : mult_on_r;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      mwdma_sel <= 3'h0;
      udma_sel <= 7'h00;
      mult_count_r <= `MULT_RESET;
      mult_on_r <= 1'b1;
    end
    else
    begin
      mwdma_sel <= mwdma_nxt;
      udma_sel <= udma_nxt;
      mult_count_r <= mult_count_nxt;
      mult_on_r <= mult_on_nxt;
    end

  // one done or reject pulse per request cycle; a taken and a refused request in one cycle raise both
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      set_done <= 1'b0;
      set_reject <= 1'b0;
    end
    else
    begin
      set_done <= mode_take || mult_take;
      set_reject <= any_reject;
    end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      sectors_r <= `SECTORS_RESET;
    else if (cap_load)
      sectors_r <= cap_sectors;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      words_64_70_valid <= 1'b0;
    else
      words_64_70_valid <= fields_present;

  ////////////////////////////////////////////////////////////////////
  // word assembly

  wire [15:0] mult_word = mult_on_r ?
                          {7'h00, 1'b1, mult_count_r} : 16'h0000;
  wire [15:0] mwdma_word = {5'h00, mwdma_sel, 5'h00, mw_sup};

  // high word matches low
  // reading the low word freezes the high half, so a pair read
  // never tears across a capacity update
  wire sect_lo_rd = rd_req && (rd_index == `W_SECT_LO);
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      sect_hi_snap_r <= 16'h0000;
    else if (sect_lo_rd)
      sect_hi_snap_r <= sectors_r[31:16];

  // only defined bits pass; a widened strap cannot leak into
  // reserved positions
  wire [15:0] mult_out = mult_word & `MULT_USED_MASK;
  wire [15:0] mwdma_out = mwdma_word & `MWDMA_USED_MASK;
  wire [15:0] queue_out = queue_word & `QUEUE_USED_MASK;

  wire [15:0] valid_mask = fields_present ? 16'hFFFF : 16'h0000;
  wire [15:0] pio_out = pio_word & `PIO_USED_MASK & valid_mask;
  wire [15:0] dma_min_out = dma_min_word & valid_mask;
  wire [15:0] dma_rec_out = dma_rec_word & valid_mask;
  wire [15:0] nofc_out = nofc_word & valid_mask;
  wire [15:0] iordy_out = iordy_word & valid_mask;

  logic [15:0] word_sel;
  always_comb
  begin
    word_sel = 16'h0000;
    case (rd_index)
      `W_MULT_SET: word_sel = mult_out;
      `W_SECT_LO: word_sel = sectors_r[15:0];
      `W_SECT_HI: word_sel = sect_hi_snap_r;
      `W_MWDMA: word_sel = mwdma_out;
      `W_PIO_SUP: word_sel = pio_out;
      `W_DMA_MIN: word_sel = dma_min_out;
      `W_DMA_REC: word_sel = dma_rec_out;
      `W_PIO_NOFC: word_sel = nofc_out;
      `W_PIO_IORDY: word_sel = iordy_out;
      `W_QUEUE: word_sel = queue_out;
      default: word_sel = 16'h0000;
    endcase
  end

  // answer one cycle after the request
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      rd_valid <= 1'b0;
    else
      rd_valid <= rd_req;

  // data holds until the next request, so a slow host may sample late
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      rd_data <= 16'h0000;
    else if (rd_req)
      rd_data <= word_sel;

  ////////////////////////////////////////////////////////////////////
  // queue accounting

  queue_track_if qt ();
  assign qt.accept = cmd_accept;
  assign qt.complete = cmd_complete;
  assign qt.limit = queue_limit;

  cmd_queue_tracker u_queue
  (
    .mclk(mclk),
    .rst(rst),
    .q(qt)
  );

  assign queue_count = qt.count;
  assign queue_full = qt.full;
  assign queue_overflow = qt.overflow;

  ////////////////////////////////////////////////////////////////////
  // host pacing against the recommended dma cycle

  // only meaningful while a multiword mode is selected; in any other
  // mode the throttle stays idle
  wire mw_selected = (mwdma_sel != 3'h0);
  wire pace_strobe = dma_word_strobe && mw_selected;

  dma_pace_monitor u_pace
  (
    .mclk(mclk),
    .rst(rst),
    .word_strobe(pace_strobe),
    .rec_ns(dma_rec_word),
    .throttle(dmarq_throttle)
  );

endmodule

// ### src/queue_track_if.sv
// carrier between the identify block and its queue tracker
// assumes: one owner and one user, same clock
`timescale 1ns/1ps
interface queue_track_if;
  logic accept;
  logic complete;
  logic full;
  logic overflow;
  logic [5:0] limit;
  logic [5:0] count;
  modport owner (input accept, input complete, input limit,
                 output count, output full, output overflow);
  modport user (output accept, output complete, output limit,
                input count, input full, input overflow);
endinterface

// ### testbench/host_reader.sv
// host adapter model: reads identify words one at a time
// assumes: device answers with rd_valid one cycle after the request
`timescale 1ns/1ps
module host_reader
(
  input wire logic mclk,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic words_64_70_valid,
  output logic rd_req,
  output logic [7:0] rd_index
);
  initial
  begin
    rd_req = 1'b0;
    rd_index = 8'hFF;
  end
  ////////////////////////////////////////////////////////////////
  task automatic read_word(input logic [7:0] idx, output logic [15:0] data);
    @(posedge mclk);
    #1;
    rd_req = 1'b1;
    rd_index = idx;
    @(posedge mclk);
    #1;
    rd_req = 1'b0;
    // idle index changes so a stale decode shows
    rd_index = ~idx;
    data = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
    if (idx >= 8'h40 && idx <= 8'h46 && words_64_70_valid !== 1'b1)
      data = 16'hXXXX;
  endtask
endmodule

// ### testbench/ident_xfer_words_properties.sv
// concurrent checks on the identify transfer-capability words
// assumes: bound to ident_xfer_words, single clock mclk
`timescale 1ns/1ps
`include "ident_xfer_map.svh"
module ident_xfer_words_checker
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic [7:0] rd_index,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic mult_set_req,
  input wire logic mode_set_req,
  input wire logic set_done,
  input wire logic set_reject,
  input wire logic cmd_accept,
  input wire logic cmd_complete,
  input wire logic [5:0] queue_count,
  input wire logic queue_full,
  input wire logic dmarq_throttle,
  input wire logic words_64_70_valid,
  input wire logic [2:0] mwdma_sel,
  input wire logic [6:0] udma_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  sequence s_rd(logic [7:0] idx);
    rd_req && rd_index == idx ##1 rd_valid;
  endsequence
  sequence s_hold6;
    dmarq_throttle [*6];
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_RD_ANSWER:
    assert property (rd_req |=> rd_valid) else $error("read not answered");
  AST_MW_RSV:
    assert property (s_rd(`W_MWDMA) |-> rd_data[15:11] == 5'h00 && rd_data[7:3] == 5'h00)
    else $error("reserved dma word bits set");
  AST_MW_SUP:
    assert property (s_rd(`W_MWDMA) |-> rd_data[0] && (!rd_data[2] || rd_data[1])
      && (!rd_data[1] || rd_data[0])) else $error("dma support bits inconsistent");
  AST_MW_SEL:
    assert property (s_rd(`W_MWDMA) |-> $onehot0(rd_data[10:8])
      && rd_data[10:8] == $past(mwdma_sel)) else $error("dma selected bits wrong");
  AST_ONE_DMA:
    assert property (!((|mwdma_sel) && (|udma_sel)) && $onehot0(udma_sel))
    else $error("two dma modes selected");
  AST_PIO:
    assert property (s_rd(`W_PIO_SUP) |-> rd_data[0] && rd_data[15:2] == 14'h0000)
    else $error("pio modes field wrong");
  AST_IORDY:
    assert property (s_rd(`W_PIO_IORDY) |-> rd_data != 16'h0000 && rd_data <= 16'h00B4)
    else $error("iordy cycle out of range");
  AST_QDEPTH:
    assert property (s_rd(`W_QUEUE) |-> rd_data[15:5] == 11'h000)
    else $error("queue word upper bits set");
  AST_VALID:
    assert property (!$past(rst) |-> words_64_70_valid) else $error("validity flag low");
  AST_Q_INC:
    assert property (cmd_accept && !cmd_complete && !queue_full
      |=> queue_count == $past(queue_count) + 6'h01) else $error("accept not counted");
  AST_Q_BOTH:
    assert property (cmd_accept && cmd_complete && !queue_full && queue_count != 6'h00
      |=> $stable(queue_count)) else $error("count moved on accept and complete");
  AST_THROTTLE:
    assert property ($rose(dmarq_throttle) |-> s_hold6) else $error("throttle too short");
  AST_SET:
    assert property ((mult_set_req ^ mode_set_req) |=> set_done ^ set_reject)
    else $error("set not answered");
endmodule

bind ident_xfer_words ident_xfer_words_checker ident_xfer_words_checker_i (.mclk, .rst,
  .rd_req, .rd_index, .rd_data, .rd_valid, .mult_set_req, .mode_set_req, .set_done,
  .set_reject, .cmd_accept, .cmd_complete, .queue_count, .queue_full, .dmarq_throttle,
  .words_64_70_valid, .mwdma_sel, .udma_sel);

// ### testbench/tb_top.sv
// self-checking bench for the identify transfer-capability words
// assumes: host_reader issues reads, bench drives the device side
`timescale 1ns/1ps
`include "ident_xfer_map.svh"
module tb_top import ident_xfer_pkg::*;
;
  logic mclk, rst, rd_req, rd_valid, mult_set_req, mode_set_req, set_done, set_reject;
  logic cap_load, cmd_accept, cmd_complete, queue_full, queue_overflow;
  logic dma_word_strobe, dmarq_throttle, words_64_70_valid;
  logic [7:0] rd_index, mult_set_count, mode_set_value;
  logic [31:0] cap_sectors;
  ident_word_t rd_data;
  logic [5:0] queue_count;
  logic [2:0] mwdma_sel;
  logic [6:0] udma_sel;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  ident_xfer_words ident_xfer_words_i (.mclk, .rst, .rd_req, .rd_index, .rd_data,
    .rd_valid, .mult_set_req, .mult_set_count, .mode_set_req, .mode_set_value, .set_done,
    .set_reject, .cap_load, .cap_sectors, .cmd_accept, .cmd_complete, .queue_count,
    .queue_full, .queue_overflow, .dma_word_strobe, .dmarq_throttle, .words_64_70_valid,
    .mwdma_sel, .udma_sel);
  host_reader host_reader_i (.mclk, .rd_valid, .rd_data, .words_64_70_valid, .rd_req,
    .rd_index);
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] idx, input ident_word_t exp);
    ident_word_t d;
    host_reader_i.read_word(idx, d);
    chk(d, exp);
  endtask
  task automatic set_req(input logic mode, input logic [7:0] v, input logic ok);
    @(posedge mclk);
    #1;
    mode_set_req = mode;
    mult_set_req = !mode;
    mode_set_value = v;
    mult_set_count = v;
    @(posedge mclk);
    #1;
    mode_set_req = 1'b0;
    mult_set_req = 1'b0;
    chk({set_done, set_reject}, {ok, !ok});
  endtask
  task automatic pulse(input logic a, input logic c, input logic s, input logic l);
    @(posedge mclk);
    #1;
    {cmd_accept, cmd_complete, dma_word_strobe, cap_load} = {a, c, s, l};
    @(posedge mclk);
    #1;
    {cmd_accept, cmd_complete, dma_word_strobe, cap_load} = 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_idle_words;
    rd(`W_MULT_SET, 16'h0110);
    rd(`W_MWDMA, 16'h0007);
    rd(`W_PIO_SUP, 16'h0003);
    rd(`W_DMA_MIN, 16'h0078);
    rd(`W_DMA_REC, 16'h0078);
    rd(`W_PIO_NOFC, 16'h0078);
    rd(`W_PIO_IORDY, 16'h0078);
    rd(`W_QUEUE, 16'h001F);
    rd(8'h45, 16'h0000);
    rd(8'h3E, 16'h0000);
  endtask
  task automatic t_capacity;
    cap_sectors = 32'hA5C3_1E87;
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    rd(`W_SECT_LO, 16'h1E87);
    rd(`W_SECT_HI, 16'hA5C3);
  endtask
  task automatic t_modes;
    for (int n = 0; n < 3; n++)
    begin
      set_req(1'b1, 8'h20 + n[7:0], 1'b1);
      rd(`W_MWDMA, {5'h00, 3'b001 << n, 8'h07});
    end
    set_req(1'b1, 8'h45, 1'b1);
    chk({mwdma_sel, udma_sel}, {3'b000, 7'h20});
    set_req(1'b1, 8'h23, 1'b0);
    set_req(1'b1, 8'h0C, 1'b1);
    chk({mwdma_sel, udma_sel}, {3'b000, 7'h20});
    set_req(1'b1, 8'h22, 1'b1);
    chk({mwdma_sel, udma_sel}, {3'b100, 7'h00});
  endtask
  task automatic t_mult;
    set_req(1'b0, 8'h08, 1'b1);
    rd(`W_MULT_SET, 16'h0108);
    set_req(1'b0, 8'h11, 1'b0);
    rd(`W_MULT_SET, 16'h0108);
    set_req(1'b0, 8'h10, 1'b1);
    rd(`W_MULT_SET, 16'h0110);
    set_req(1'b0, 8'h00, 1'b1);
    rd(`W_MULT_SET, 16'h0000);
  endtask
  task automatic t_queue;
    repeat (32) pulse(1'b1, 1'b0, 1'b0, 1'b0);
    chk({queue_full, queue_count}, {1'b1, 6'h20});
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    chk({queue_overflow, queue_count}, {1'b1, 6'h20});
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    chk({queue_full, queue_count}, {1'b0, 6'h1F});
    repeat (32) pulse(1'b0, 1'b1, 1'b0, 1'b0);
    chk(queue_count, 6'h00);
  endtask
  task automatic t_pace;
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    // first strobe only arms the spacing count
    chk(dmarq_throttle, 1'b0);
    @(posedge mclk);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    chk(dmarq_throttle, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge mclk);
      #1;
      chk(dmarq_throttle, i < 5);
    end
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    // spacing of exactly six cycles is not too fast
    repeat (4) @(posedge mclk);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    @(posedge mclk);
    #1;
    chk(dmarq_throttle, 1'b0);
  endtask
  task automatic t_rerun;
    @(posedge mclk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk({mwdma_sel, udma_sel}, 10'h000);
    rd(`W_MULT_SET, 16'h0110);
    chk(words_64_70_valid, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      stop_test;
    end
  end
  initial
  begin
    rst = 1'b1;
    {mult_set_req, mode_set_req, cap_load, cmd_accept, cmd_complete} = 5'h00;
    dma_word_strobe = 1'b0;
    mult_set_count = 8'h00;
    mode_set_value = 8'h00;
    cap_sectors = 32'h0000_0000;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_idle_words;
    t_capacity;
    t_modes;
    t_mult;
    t_queue;
    t_pace;
    t_rerun;
    stop_test;
  end
endmodule
